// [design/adc_ctrl_pkg.sv]
/*
  Shared constants and types for the converter control block:
  channel select codes, conversion clock choices, widths and the state encoding.
  Assumes a single bus-clock domain; every other clock reaches the block as a sampled pin.
*/
package adc_ctrl_pkg;

  // ==========================================================================
  // widths
  localparam int CHAN_W     = 5;
  localparam int RES_W      = 10;
  localparam int EXT_INPUTS = 6;
  localparam int CNT_W      = 8;
  localparam int CLKSEL_W   = 2;

  // ==========================================================================
  // channel select codes
  localparam logic [CHAN_W-1:0] CHAN_EXT_LAST    = 5'h05;
  localparam logic [CHAN_W-1:0] CHAN_REFL_FIRST  = 5'h06;
  localparam logic [CHAN_W-1:0] CHAN_REFL_LAST   = 5'h10;
  localparam logic [CHAN_W-1:0] CHAN_LCD_BIAS    = 5'h15;
  localparam logic [CHAN_W-1:0] CHAN_TEMP_SENSOR = 5'h1A;
  localparam logic [CHAN_W-1:0] CHAN_BANDGAP     = 5'h1B;
  localparam logic [CHAN_W-1:0] CHAN_REFH_FIRST  = 5'h1C;
  localparam logic [CHAN_W-1:0] CHAN_REFH_LAST   = 5'h1D;
  localparam logic [CHAN_W-1:0] CHAN_REFL_UPPER  = 5'h1E;
  localparam logic [CHAN_W-1:0] CHAN_DISABLED    = 5'h1F;

  // ==========================================================================
  // conversion clock select codes
  localparam logic [CLKSEL_W-1:0] CLK_BUS      = 2'h0;
  localparam logic [CLKSEL_W-1:0] CLK_BUS_DIV2 = 2'h1;
  localparam logic [CLKSEL_W-1:0] CLK_ALT      = 2'h2;
  localparam logic [CLKSEL_W-1:0] CLK_ASYNC    = 2'h3;

  // ==========================================================================
  // result formatting and reset values
  localparam int                RES8_SHIFT  = 2;
  localparam logic [RES_W-1:0]  MSB_MASK    = 10'h200;
  localparam logic [RES_W-1:0]  RES_RESET   = 10'h000;
  localparam logic [CHAN_W-1:0] CHAN_RESET  = CHAN_DISABLED;
  localparam logic [CNT_W-1:0]  CNT_RESET   = 8'h00;

  // ==========================================================================
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    st_idle    = 3'b001,
    st_sample  = 3'b010,
    st_convert = 3'b100
  } conv_state_type;

endpackage : adc_ctrl_pkg

// [design/conv_sync_edge.sv]
/*
  Two-flop synchroniser with a rising-edge pulse for one asynchronous level.
  Assumes the input is slower than half the clock so that each edge is seen.
*/
module conv_sync_edge (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // ==========================================================================
  // synchroniser, first flop only feeds the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~last_reg;

endmodule : conv_sync_edge

// [design/adc_channel_clock_trigger_ctrl.sv]
/*
  Control logic around a 10-bit successive-approximation converter: channel
  decode, conversion clock choice, software or timer trigger, single or
  continuous runs, result formatting, compare and the complete flag.
  Assumes register decode lives outside: writes to the first status and
  control register arrive as ctrl_write with its fields, other settings are
  live levels, and the analog comparator output is asynchronous.
*/

// Notes on behaviour
// - codes 0-5 pick inputs, ones disable
// - low/high reference, lcd bias, bandgap codes
// - code 26 selects temperature sensor
// - reserved codes give undefined results
// - four selectable conversion clock sources
// - alternate clock is clock unit reference
// - timer overflow starts hardware-triggered conversion
// - single or continuous; single returns idle
// - result right-justified, 10 or 8 bits
// - linear successive approximation, ten bits
// - optional compare, less or greater-equal
// - complete flag, interrupt when enabled
// - sample time and power configurable
// - keeps converting in wait and stop
// - control write aborts, restarts unless disabled or hardware-triggered
// - flag set rules; cleared by write/read
// - all-ones code powers off, no extra
// - trigger select: software write or hardware
module adc_channel_clock_trigger_ctrl #(
  parameter int SAMPLE_SHORT = 4,
  parameter int SAMPLE_LONG  = 16,
  parameter int SETTLE       = 3
) (
  input  wire logic                                core_clk,
  input  wire logic                                resetn,
  input  wire logic                                ctrl_write,
  input  wire logic [adc_ctrl_pkg::CHAN_W-1:0]     wr_input_channel_select,
  input  wire logic                                wr_conversion_irq_enable,
  input  wire logic                                wr_continuous_conversion_enable,
  input  wire logic                                trigger_type_select,
  input  wire logic                                compare_function_enable,
  input  wire logic                                compare_greater_equal,
  input  wire logic [adc_ctrl_pkg::RES_W-1:0]      compare_value,
  input  wire logic                                result_8bit_mode,
  input  wire logic [adc_ctrl_pkg::CLKSEL_W-1:0]   conv_clock_select,
  input  wire logic                                long_sample_enable,
  input  wire logic                                low_power_enable,
  input  wire logic                                result_low_read,
  input  wire logic                                hardware_trigger_input,
  input  wire logic                                local_async_conv_clock,
  input  wire logic                                clock_unit_ext_ref_clock,
  input  wire logic                                comparator_in,
  output logic [adc_ctrl_pkg::EXT_INPUTS-1:0]      analog_input_sel,
  output logic                                     reference_low_sel,
  output logic                                     reference_high_sel,
  output logic                                     lcd_bias_level_one_sel,
  output logic                                     temp_sensor_sel,
  output logic                                     bandgap_sel,
  output logic                                     converter_power_on,
  output logic                                     converter_low_power,
  output logic                                     sample_enable,
  output logic [adc_ctrl_pkg::RES_W-1:0]           dac_code,
  output logic [adc_ctrl_pkg::RES_W-1:0]           result_data,
  output logic                                     conversion_complete_flag,
  output logic                                     conversion_active,
  output logic                                     conversion_irq
);
  import adc_ctrl_pkg::*;

  if (SAMPLE_SHORT < 1 || SAMPLE_LONG < SAMPLE_SHORT || SAMPLE_LONG > 255 || SETTLE < 1 || SETTLE > 255) begin : g_chk
    $error("sample or settle count out of range");
  end

  logic                 rst_meta_reg;
  logic                 rst_n;
  logic                 trig_rise;
  logic                 async_rise;
  logic                 alt_rise;
  logic                 cmp_level;
  logic                 div2_reg;
  logic                 conv_tick;
  logic [CHAN_W-1:0]    chan_reg;
  logic                 irq_en_reg;
  logic                 cont_reg;
  conv_state_type       state_reg;
  conv_state_type       state_next;
  logic [CNT_W-1:0]     sample_cnt_reg;
  logic [CNT_W-1:0]     settle_cnt_reg;
  logic [RES_W-1:0]     code_reg;
  logic [RES_W-1:0]     mask_reg;
  logic [RES_W-1:0]     code_step;
  logic [RES_W-1:0]     result_fmt;
  logic [RES_W-1:0]     result_reg;
  logic                 flag_reg;
  logic                 chan_off;
  logic                 wr_off;
  logic                 hw_start;
  logic                 step;
  logic                 done_evt;
  logic                 match;
  logic                 flag_set;
  logic                 flag_clr;
  logic                 enter_sample;
  logic                 enter_convert;
  logic [CNT_W-1:0]     sample_load;

  // ==========================================================================
  // reset release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // pin synchronisers
  conv_sync_edge u_trig (.core_clk(core_clk), .rst_n(rst_n), .async_in(hardware_trigger_input),
                         .level_out(), .rise_out(trig_rise));
  conv_sync_edge u_async (.core_clk(core_clk), .rst_n(rst_n), .async_in(local_async_conv_clock),
                          .level_out(), .rise_out(async_rise));
  // alternate source is the clock unit reference, no separate pin
  conv_sync_edge u_alt (.core_clk(core_clk), .rst_n(rst_n), .async_in(clock_unit_ext_ref_clock),
                        .level_out(), .rise_out(alt_rise));
  conv_sync_edge u_cmp (.core_clk(core_clk), .rst_n(rst_n), .async_in(comparator_in),
                        .level_out(cmp_level), .rise_out());

  // ==========================================================================
  // conversion clock as a tick on the bus clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) div2_reg <= 1'b0;
    else        div2_reg <= ~div2_reg;
  end

  assign conv_tick = (conv_clock_select == CLK_BUS)      ? 1'b1 :
                     (conv_clock_select == CLK_BUS_DIV2) ? div2_reg :
                     (conv_clock_select == CLK_ALT)      ? alt_rise : async_rise;

  // ==========================================================================
  // channel decode; reserved codes select nothing, result is then undefined
  genvar gi;
  for (gi = 0; gi < EXT_INPUTS; gi++) begin : g_ext
    assign analog_input_sel[gi] = (chan_reg == CHAN_W'(gi));
  end
  assign reference_low_sel      = (chan_reg >= CHAN_REFL_FIRST && chan_reg <= CHAN_REFL_LAST)
                                || chan_reg == CHAN_REFL_UPPER;
  assign reference_high_sel     = (chan_reg >= CHAN_REFH_FIRST && chan_reg <= CHAN_REFH_LAST);
  assign lcd_bias_level_one_sel = (chan_reg == CHAN_LCD_BIAS);
  assign bandgap_sel            = (chan_reg == CHAN_BANDGAP);
  assign temp_sensor_sel        = (chan_reg == CHAN_TEMP_SENSOR);
  assign chan_off               = (chan_reg == CHAN_DISABLED);
  assign wr_off                 = (wr_input_channel_select == CHAN_DISABLED);

  // ==========================================================================
  // control fields captured on a write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg   <= CHAN_RESET;
      irq_en_reg <= 1'b0;
      cont_reg   <= 1'b0;
    end else if (ctrl_write) begin
      chan_reg   <= wr_input_channel_select;
      irq_en_reg <= wr_conversion_irq_enable;
      cont_reg   <= wr_continuous_conversion_enable;
    end
  end

  // ==========================================================================
  // sequencer
  assign hw_start   = trig_rise && trigger_type_select && !chan_off;
  assign step       = (state_reg == st_convert) && conv_tick && (settle_cnt_reg == CNT_RESET);
  assign done_evt   = step && mask_reg[0];
  assign sample_load = long_sample_enable ? CNT_W'(SAMPLE_LONG - 1) : CNT_W'(SAMPLE_SHORT - 1);

  always_comb begin
    state_next = state_reg;
    if (ctrl_write) begin
      // a write aborts; software trigger restarts at once, hardware waits
      if (wr_off || trigger_type_select) state_next = st_idle;
      else                               state_next = st_sample;
    end else begin
      case (state_reg)
        st_idle: begin
          if (hw_start) state_next = st_sample;
        end
        st_sample: begin
          if (conv_tick && sample_cnt_reg == CNT_RESET) state_next = st_convert;
        end
        st_convert: begin
          if (done_evt) state_next = (cont_reg && !chan_off) ? st_sample : st_idle;
        end
        default: state_next = st_idle;
      endcase
    end
  end

  assign enter_sample  = (state_next == st_sample) && (state_reg != st_sample || ctrl_write);
  assign enter_convert = (state_next == st_convert) && (state_reg == st_sample);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) state_reg <= st_idle;
    else        state_reg <= state_next;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)                                   sample_cnt_reg <= CNT_RESET;
    else if (enter_sample)                        sample_cnt_reg <= sample_load;
    else if (state_reg == st_sample && conv_tick) sample_cnt_reg <= sample_cnt_reg - 1'b1;
  end

  // comparator passes a synchroniser, so each trial waits for it to settle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)                                  settle_cnt_reg <= CNT_RESET;
    else if (enter_convert || step)              settle_cnt_reg <= CNT_W'(SETTLE);
    else if (settle_cnt_reg != CNT_RESET)        settle_cnt_reg <= settle_cnt_reg - 1'b1;
  end

  // ==========================================================================
  // successive approximation, most significant bit first
  assign code_step = (cmp_level ? code_reg : (code_reg & ~mask_reg)) | (mask_reg >> 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= RES_RESET;
      mask_reg <= RES_RESET;
    end else if (enter_convert) begin
      code_reg <= MSB_MASK;
      mask_reg <= MSB_MASK;
    end else if (step) begin
      code_reg <= code_step;
      mask_reg <= mask_reg >> 1;
    end
  end

  // ==========================================================================
  // result, compare and complete flag
  assign result_fmt = result_8bit_mode ? (code_step >> RES8_SHIFT) : code_step;
  assign match      = compare_greater_equal ? (result_fmt >= compare_value)
                                            : (result_fmt < compare_value);
  assign flag_set   = done_evt && (!compare_function_enable || match);
  assign flag_clr   = ctrl_write || result_low_read;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)        result_reg <= RES_RESET;
    else if (done_evt) result_reg <= result_fmt;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) flag_reg <= 1'b0;
    else        flag_reg <= flag_set | (flag_reg & ~flag_clr);
  end

  // ==========================================================================
  // outputs; no stop or wait input exists, so conversions run on regardless
  assign converter_power_on       = (state_reg != st_idle);
  assign converter_low_power      = low_power_enable;
  assign sample_enable            = (state_reg == st_sample);
  assign conversion_active        = (state_reg != st_idle);
  assign dac_code                 = code_reg;
  assign result_data              = result_reg;
  assign conversion_complete_flag = flag_reg;
  assign conversion_irq           = flag_reg & irq_en_reg;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sw_write;
    ctrl_write && !wr_off && !trigger_type_select;
  endsequence

  sequence s_off_write;
    ctrl_write && wr_off;
  endsequence

  sequence s_single_done;
    done_evt && !cont_reg;
  endsequence

  a_ext_input_map: assert property (chan_reg <= CHAN_EXT_LAST |-> analog_input_sel == (6'h01 << chan_reg)
                                    && !reference_low_sel)
    else $error("external input select wrong");
  a_ref_low_map: assert property ((chan_reg == CHAN_REFL_UPPER || chan_reg == CHAN_REFL_FIRST)
                                  |-> reference_low_sel && !reference_high_sel && analog_input_sel == 6'h00)
    else $error("low reference not selected");
  a_temp_map: assert property (chan_reg == CHAN_TEMP_SENSOR |-> temp_sensor_sel && !bandgap_sel)
    else $error("temperature sensor not selected");
  // a new write right after the off write may legally restart, so it is excluded
  a_disable_off: assert property (s_off_write ##1 !ctrl_write |-> state_reg == st_idle && !converter_power_on
                                  ##1 !converter_power_on)
    else $error("disabled code left converter on");
  a_write_start: assert property (s_sw_write |=> state_reg == st_sample && sample_enable)
    else $error("write did not restart conversion");
  a_hw_start: assert property (state_reg == st_idle && hw_start && !ctrl_write |=> state_reg == st_sample)
    else $error("hardware trigger ignored");
  a_hw_waits: assert property (ctrl_write && trigger_type_select |=> state_reg == st_idle)
    else $error("hardware mode started on write");
  a_single_idle: assert property ((s_single_done and !ctrl_write) |=> state_reg == st_idle && !converter_power_on)
    else $error("single conversion did not return idle");
  a_flag_set: assert property (done_evt && !compare_function_enable |=> conversion_complete_flag)
    else $error("flag not set after conversion");
  a_flag_clear: assert property (result_low_read && !flag_set |=> !conversion_complete_flag)
    else $error("flag not cleared by read");
  a_result_8bit: assert property (done_evt && result_8bit_mode |=> result_data[9:8] == 2'b00)
    else $error("8-bit result not right-justified");
  a_irq_flag: assert property (flag_set && irq_en_reg && !ctrl_write |=> conversion_irq)
    else $error("interrupt missing on complete");

endmodule : adc_channel_clock_trigger_ctrl

// [dv/adc_far_side_model.sv]
/*
  Far side of the converter control: analog comparator, the two pin clocks
  and the periodic wakeup timer. Assumes the bench sets the analog level.
*/
module adc_far_side_model (
  input  wire logic                           core_clk,
  input  wire logic [adc_ctrl_pkg::RES_W-1:0] dac_code,
  input  wire logic [adc_ctrl_pkg::RES_W-1:0] analog_level,
  input  wire logic                           clocks_run,
  input  wire logic                           timer_on,
  output logic                                comparator_in,
  output logic                                async_clk,
  output logic                                alt_clk,
  output logic                                timer_overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctrl_pkg::*;

  // ==========================================================================
  // comparator, settles off the sampling edge
  always @(negedge core_clk) comparator_in <= (analog_level >= dac_code);

  // ==========================================================================
  // pin clocks stand still while the converter is off, both below half rate
  initial begin
    async_clk = 1'b0;
    forever #25 async_clk = clocks_run ? ~async_clk : 1'b0;
  end
  initial begin
    alt_clk = 1'b0;
    forever #15 alt_clk = clocks_run ? ~alt_clk : 1'b0;
  end

  // ==========================================================================
  // overflow pulse
  initial begin
    timer_overflow = 1'b0;
    forever begin
      #1000;
      if (timer_on) begin
        timer_overflow = 1'b1;
        #60;
        timer_overflow = 1'b0;
      end
    end
  end
endmodule : adc_far_side_model

// [dv/adc_channel_clock_trigger_ctrl_tb.sv]
/*
  Self-checking bench for the converter control block.
  Assumes the design package and the far-side model are compiled first.
*/
module adc_channel_clock_trigger_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctrl_pkg::*;

  localparam int SHORT_T = 2;
  localparam int LONG_T  = 5;

  logic                  core_clk, resetn, ctrl_write, wr_irq, wr_cont, trig_sel, cmp_en, cmp_ge;
  logic                  res8, long_samp, low_pwr, low_read, timer_on, hw_trig, async_clk, alt_clk, comp;
  logic                  refl, refh, lcd, temp, bg, pwr_on, low_pwr_out, samp_en, flag, active, irq, seen;
  logic [CHAN_W-1:0]     wr_chan;
  logic [CLKSEL_W-1:0]   clk_sel;
  logic [RES_W-1:0]      cmp_val, level, dac, result;
  logic [EXT_INPUTS-1:0] ain_sel;
  int                    fails = 0, tests_run = 0, cycles = 0, samp_cnt;

  adc_channel_clock_trigger_ctrl #(.SAMPLE_SHORT(SHORT_T), .SAMPLE_LONG(LONG_T), .SETTLE(3))
    adc_channel_clock_trigger_ctrl_inst (
    .core_clk(core_clk), .resetn(resetn), .ctrl_write(ctrl_write), .wr_input_channel_select(wr_chan),
    .wr_conversion_irq_enable(wr_irq), .wr_continuous_conversion_enable(wr_cont),
    .trigger_type_select(trig_sel), .compare_function_enable(cmp_en), .compare_greater_equal(cmp_ge),
    .compare_value(cmp_val), .result_8bit_mode(res8), .conv_clock_select(clk_sel),
    .long_sample_enable(long_samp), .low_power_enable(low_pwr), .result_low_read(low_read),
    .hardware_trigger_input(hw_trig), .local_async_conv_clock(async_clk),
    .clock_unit_ext_ref_clock(alt_clk), .comparator_in(comp), .analog_input_sel(ain_sel),
    .reference_low_sel(refl), .reference_high_sel(refh), .lcd_bias_level_one_sel(lcd),
    .temp_sensor_sel(temp), .bandgap_sel(bg), .converter_power_on(pwr_on),
    .converter_low_power(low_pwr_out), .sample_enable(samp_en), .dac_code(dac), .result_data(result),
    .conversion_complete_flag(flag), .conversion_active(active), .conversion_irq(irq));

  adc_far_side_model adc_far_side_model_inst (
    .core_clk(core_clk), .dac_code(dac), .analog_level(level), .clocks_run(pwr_on),
    .timer_on(timer_on), .comparator_in(comp), .async_clk(async_clk), .alt_clk(alt_clk),
    .timer_overflow(hw_trig));

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic ctrl_wr(input logic [CHAN_W-1:0] chan, input logic cont);
    @(negedge core_clk);
    ctrl_write = 1'b1;
    wr_chan = chan;
    wr_cont = cont;
    @(negedge core_clk);
    ctrl_write = 1'b0;
  endtask : ctrl_wr

  // first sample cycle already passed inside ctrl_wr, so it is counted up front
  task automatic wait_sig(input bit for_flag);
    int n;
    n = 0;
    samp_cnt = (samp_en === 1'b1);
    while ((for_flag ? flag !== 1'b1 : active !== 1'b0) && n < 3000) begin
      @(negedge core_clk);
      n++;
      if (samp_en === 1'b1) samp_cnt++;
    end
    check("wait_bound", n < 3000, 1'b1);
  endtask : wait_sig

  // {bandgap, temp, lcd bias, ref high, ref low, inputs}
  function automatic logic [15:0] decode_exp(input int c);
    logic [15:0] d;
    d = '0;
    if (c <= 5) d[c] = 1'b1;
    d[6] = (c >= 6 && c <= 16) || c == 30;
    d[7] = c == 28 || c == 29;
    d[8] = c == 21;
    d[9] = c == 26;
    d[10] = c == 27;
    return d;
  endfunction : decode_exp

  // ==========================================================================
  // clock and hang limit
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    {resetn, ctrl_write, wr_cont, trig_sel, cmp_en, cmp_ge, res8, long_samp, low_pwr, low_read} = '0;
    {timer_on, clk_sel, cmp_val} = '0;
    wr_irq = 1'b1;
    wr_chan = CHAN_DISABLED;
    level = 10'h2A5;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    check("reset_power", pwr_on, 1'b0);
    check("reset_flag", flag, 1'b0);
    trig_sel = 1'b1;
    for (int c = 0; c < 32; c++) begin
      ctrl_wr(CHAN_W'(c), 1'b0);
      check("decode", {bg, temp, lcd, refh, refl, ain_sel}, decode_exp(c));
      check("hw_no_start", active, 1'b0);
    end
    ctrl_wr(5'h03, 1'b0);
    repeat (20) @(negedge core_clk);
    check("hw_wait", active, 1'b0);
    timer_on = 1'b1;
    wait_sig(1'b1);
    timer_on = 1'b0;
    check("hw_result", result, 10'h2A5);
    check("hw_irq", irq, 1'b1);
    check("hw_idle", {active, pwr_on}, 2'b00);
    @(negedge core_clk);
    low_read = 1'b1;
    @(negedge core_clk);
    low_read = 1'b0;
    check("read_clear", {flag, irq}, 2'b00);
    trig_sel = 1'b0;
    level = 10'h3C3;
    // every clock source, then long sample on the bus clock
    for (int s = 0; s < 5; s++) begin
      clk_sel = (s == 4) ? CLK_BUS : CLKSEL_W'(s);
      long_samp = (s == 4);
      low_pwr = s[1];
      wr_irq = s[0];
      ctrl_wr(5'h02, 1'b0);
      check("src_sel", ain_sel, 6'h04);
      wait_sig(1'b1);
      check("src_result", result, 10'h3C3);
      check("src_irq", irq, s[0]);
      check("low_power", low_pwr_out, low_pwr);
      if (s == 0) check("short_sample", samp_cnt, SHORT_T);
      if (s == 4) check("long_sample", samp_cnt, LONG_T);
      @(negedge core_clk);
      check("single_idle", {active, pwr_on}, 2'b00);
    end
    res8 = 1'b1;
    ctrl_wr(5'h02, 1'b0);
    wait_sig(1'b1);
    check("res8", result, 10'h0F0);
    res8 = 1'b0;
    cmp_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cmp_ge = i[1];
      cmp_val = 10'h3C3 + RES_W'(i[0]);
      ctrl_wr(5'h02, 1'b0);
      wait_sig(1'b0);
      @(negedge core_clk);
      check("compare_flag", flag, cmp_ge ^ i[0]);
    end
    cmp_en = 1'b0;
    level = 10'h155;
    ctrl_wr(5'h00, 1'b1);
    wait_sig(1'b1);
    check("cont_result", result, 10'h155);
    check("cont_running", active, 1'b1);
    @(negedge core_clk);
    low_read = 1'b1;
    @(negedge core_clk);
    low_read = 1'b0;
    check("cont_read", flag, 1'b0);
    wait_sig(1'b1);
    check("cont_again", result, 10'h155);
    repeat (10) @(negedge core_clk);
    level = 10'h0AA;
    ctrl_wr(5'h00, 1'b1);
    check("abort", {flag, active}, 2'b01);
    wait_sig(1'b1);
    check("abort_result", result, 10'h0AA);
    ctrl_wr(CHAN_DISABLED, 1'b1);
    seen = 1'b0;
    repeat (200) begin
      @(negedge core_clk);
      if (active !== 1'b0 || pwr_on !== 1'b0 || flag !== 1'b0) seen = 1'b1;
    end
    check("off_stays", seen, 1'b0);
    end_of_test();
  end
endmodule : adc_channel_clock_trigger_ctrl_tb
